// ### rtl/zaol_core.sv
/*
  zone alarm output logic: eight zones, mapping matrix, eight mode-driven outputs,
  zone leds with flash, power-up and input-driven lamp test.
  assumes zone alarm levels already decoded from the loops, active-low push
  buttons and control inputs from pins, and configuration presented on cfg_*
  with cfg_valid high once the storage is loaded.
*/
`timescale 1ns/10ps
module zaol_core
  import zaol_pkg::*;
#(
  parameter int N = ZONES,
  parameter int TICK = TICK_CYC,
  parameter int FLASH = FLASH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N-1:0] loop_short,
  input wire logic [N-1:0] loop_open,
  input wire logic [N-1:0] zone_btn_b,
  input wire logic [3:0] din_b,
  input wire logic cfg_valid,
  input wire logic [N*MODE_W-1:0] cfg_mode,
  input wire logic [N*TIME_W-1:0] cfg_time,
  input wire logic [N*N-1:0] cfg_map,
  output logic [N-1:0] out_on,
  output logic [N-1:0] led_green,
  output logic [N-1:0] led_red,
  output logic [N-1:0] led_yellow,
  output logic sounder,
  output logic run
);
  // ------------------------------------------------------------
  // input conditioning
  // ------------------------------------------------------------
  logic [N-1:0] short_s, open_s, btn_s;
  logic [3:0] din_s;
  logic tick;

  zaol_sync #(.W(N)) u_sshort (.clk(clk), .rst_b(rst_b), .din(loop_short), .dout(short_s));
  zaol_sync #(.W(N)) u_sopen (.clk(clk), .rst_b(rst_b), .din(loop_open), .dout(open_s));
  zaol_sync #(.W(N), .INIT({N{1'b1}})) u_sbtn (.clk(clk), .rst_b(rst_b), .din(zone_btn_b),
    .dout(btn_s));
  zaol_sync #(.W(4), .INIT(4'hF)) u_sdin (.clk(clk), .rst_b(rst_b), .din(din_b), .dout(din_s));
  zaol_tick #(.CYC(TICK)) u_tick (.clk(clk), .rst_b(rst_b), .tick(tick));

  function automatic logic [MODE_W-1:0] mode_of(input logic [N*MODE_W-1:0] v, input int i);
    mode_of = v[i*MODE_W +: MODE_W];
  endfunction

  // ------------------------------------------------------------
  // configuration and sequencing
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_WAIT, ST_YEL, ST_GRN, ST_RED, ST_RUN} zaol_st_e;
  zaol_st_e st_q, st_d;
  logic [N*MODE_W-1:0] mode_q, mode_d;
  logic [N*TIME_W-1:0] dur_q, dur_d;
  logic [N*N-1:0] map_q, map_d;
  logic [1:0] step_q, step_d;
  logic lamp_prev_q, lamp_prev_d;
  logic lamp_act_q, lamp_act_d;

  wire lamp_in = ~din_s[DIN_LAMP];

  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    dur_d = dur_q;
    map_d = map_q;
    step_d = step_q;
    lamp_prev_d = lamp_in;
    lamp_act_d = lamp_act_q;
    case (st_q)
      ST_WAIT: if (cfg_valid) begin
        mode_d = cfg_mode;
        dur_d = cfg_time;
        map_d = cfg_map;
        st_d = ST_YEL;
      end
      ST_YEL: if (tick) st_d = ST_GRN;
      ST_GRN: if (tick) st_d = ST_RED;
      ST_RED: if (tick) st_d = ST_RUN;
      ST_RUN: begin
        // one-shot lamp test on a fresh activation
        if (lamp_in && !lamp_prev_q && !lamp_act_q) begin
          lamp_act_d = 1'b1;
          step_d = 2'h0;
        end else if (lamp_act_q && tick) begin
          if (step_q == 2'(DIAG_STEPS - 1)) lamp_act_d = 1'b0;
          else step_d = step_q + 2'h1;
        end
      end
      default: st_d = ST_WAIT;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_WAIT;
      mode_q <= {N{MODE_DEF}};
      dur_q <= {N{TIMED_DEF_SECS}};
      map_q <= MAP_DEF;
      step_q <= 2'h0;
      lamp_prev_q <= 1'b0;
      lamp_act_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      dur_q <= dur_d;
      map_q <= map_d;
      step_q <= step_d;
      lamp_prev_q <= lamp_prev_d;
      lamp_act_q <= lamp_act_d;
    end
  end

  // ------------------------------------------------------------
  // zone state: alarm, acknowledge, reset
  // ------------------------------------------------------------
  logic [N-1:0] alarm, alarm_prev_q, alarm_rise, ack_q, ack_d, red_q, red_d;
  logic [N-1:0] btn_prev_q, press, zreset, zack, snd_q, snd_d;
  logic gack_prev_q, grst_prev_q, gack, grst;
  wire running = (st_q == ST_RUN);

  assign alarm = short_s | open_s;
  assign alarm_rise = alarm & ~alarm_prev_q;
  assign press = ~btn_s & btn_prev_q;
  assign gack = ~din_s[DIN_ACK] & gack_prev_q;
  assign grst = ~din_s[DIN_RESET] & grst_prev_q;

  always_comb begin
    ack_d = ack_q;
    red_d = red_q;
    snd_d = snd_q;
    zack = '0;
    zreset = '0;
    for (int i = 0; i < N; i++) begin
      if (running) begin
        if (alarm_rise[i]) begin
          red_d[i] = 1'b1;
          ack_d[i] = 1'b0; // new alarm flashes again
          snd_d[i] = 1'b1;
        end else if (red_q[i] && !ack_q[i] && (press[i] || gack)) begin
          zack[i] = 1'b1;
          ack_d[i] = 1'b1;
          snd_d[i] = 1'b0;
        end else if (red_q[i] && ack_q[i] && !alarm[i] && (press[i] || grst)) begin
          zreset[i] = 1'b1;
          red_d[i] = 1'b0;
          ack_d[i] = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= '0;
      red_q <= '0;
      snd_q <= '0;
      alarm_prev_q <= '0;
      btn_prev_q <= '1;
      gack_prev_q <= 1'b1;
      grst_prev_q <= 1'b1;
    end else begin
      ack_q <= ack_d;
      red_q <= red_d;
      snd_q <= snd_d;
      alarm_prev_q <= running ? alarm : alarm_prev_q;
      btn_prev_q <= btn_s;
      gack_prev_q <= din_s[DIN_ACK];
      grst_prev_q <= din_s[DIN_RESET];
    end
  end

  // ------------------------------------------------------------
  // mapping matrix and outputs
  // ------------------------------------------------------------
  logic [N-1:0] o_on_q, o_on_d, trig, trig_lvl, o_ack, o_rst;
  logic [TIME_W-1:0] o_cnt_q [N];
  logic [TIME_W-1:0] o_cnt_d [N];

  always_comb begin
    for (int o = 0; o < N; o++) begin
      trig[o] = |(alarm_rise & map_q[o*N +: N]);
      trig_lvl[o] = |(alarm & map_q[o*N +: N]);
      o_ack[o] = |(zack & map_q[o*N +: N]);
      o_rst[o] = |(zreset & map_q[o*N +: N]);
    end
  end
  always_comb begin
    o_on_d = o_on_q;
    for (int o = 0; o < N; o++) begin
      o_cnt_d[o] = o_cnt_q[o];
      if (running) begin
        case (mode_of(mode_q, o))
          MODE_NONLATCH: o_on_d[o] = trig_lvl[o];
          MODE_LATCHED: o_on_d[o] = trig[o] | (o_on_q[o] & ~o_rst[o]);
          MODE_PULSED, MODE_TIMED: begin
            if (trig[o]) begin
              o_on_d[o] = 1'b1;
              o_cnt_d[o] = (mode_of(mode_q, o) == MODE_PULSED) ? PULSE_SECS
                : dur_q[o*TIME_W +: TIME_W];
            end else if (o_rst[o]) begin
              o_on_d[o] = 1'b0;
              o_cnt_d[o] = '0;
            end else if (o_on_q[o] && tick) begin
              if (o_cnt_q[o] <= 8'h01) begin
                o_on_d[o] = 1'b0;
                o_cnt_d[o] = '0;
              end else begin
                o_cnt_d[o] = o_cnt_q[o] - 8'h01;
              end
            end
          end
          MODE_SOUNDER: o_on_d[o] = trig[o] | (o_on_q[o] & ~o_ack[o]);
          default: o_on_d[o] = 1'b0;
        endcase
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      o_on_q <= '0;
      for (int o = 0; o < N; o++) o_cnt_q[o] <= '0;
    end else begin
      o_on_q <= o_on_d;
      for (int o = 0; o < N; o++) o_cnt_q[o] <= o_cnt_d[o];
    end
  end

  // ------------------------------------------------------------
  // leds and registered outputs
  // ------------------------------------------------------------
  logic fl_tick, fl_q, fl_d;
  logic [N-1:0] g_q, g_d, r_q, r_d, y_q, y_d;
  logic s_q, s_d, run_q;

  zaol_tick #(.CYC(FLASH)) u_flash (.clk(clk), .rst_b(rst_b), .tick(fl_tick));
  always_comb begin
    fl_d = fl_q ^ fl_tick;
    g_d = ~alarm;
    r_d = red_q & (ack_q | {N{fl_q}});
    y_d = '0; // no disarm state is kept, yellow lights in operation only at lamp test step 0
    s_d = |snd_q;
    case (st_q)
      ST_WAIT: begin g_d = '0; r_d = '0; y_d = '0; s_d = 1'b0; end
      ST_YEL: begin g_d = '0; r_d = '0; y_d = '1; s_d = 1'b0; end
      ST_GRN: begin g_d = '1; r_d = '0; y_d = '0; s_d = 1'b0; end
      ST_RED: begin g_d = '0; r_d = '1; y_d = '0; s_d = 1'b0; end
      default: begin
        if (lamp_act_q) begin
          y_d = {N{step_q == 2'h0}};
          g_d = {N{step_q == 2'h1}};
          r_d = {N{step_q == 2'h2}};
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fl_q <= 1'b0;
      g_q <= '0;
      r_q <= '0;
      y_q <= '0;
      s_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      fl_q <= fl_d;
      g_q <= g_d;
      r_q <= r_d;
      y_q <= y_d;
      s_q <= s_d;
      run_q <= running;
    end
  end

  assign out_on = o_on_q;
  assign led_green = g_q;
  assign led_red = r_q;
  assign led_yellow = y_q;
  assign sounder = s_q;
  assign run = run_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  nonlatch_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 0) == MODE_NONLATCH |=> o_on_q[0] == $past(trig_lvl[0]))
    else $error("non-latching output does not follow its alarm");
  nonlatch_release_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 0) == MODE_NONLATCH && !trig_lvl[0] |=> !o_on_q[0])
    else $error("non-latching output held without alarm");
  latched_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 1) == MODE_LATCHED && o_on_q[1] && !o_rst[1] |=> o_on_q[1])
    else $error("latched output dropped without reset");
  pulse_expire_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 2) == MODE_PULSED && o_on_q[2] && tick && o_cnt_q[2] == 8'h01
    && !trig[2] |=> !o_on_q[2])
    else $error("pulsed output did not end");
  timed_load_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 3) == MODE_TIMED && trig[3] |=> o_on_q[3]
    && o_cnt_q[3] == $past(dur_q[3*TIME_W +: TIME_W]))
    else $error("timed output did not load its duration");
  reset_cuts_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 2) == MODE_PULSED && o_rst[2] && !trig[2] |=> !o_on_q[2])
    else $error("zone reset did not cut pulsed output");
  sounder_ack_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && mode_of(mode_q, 4) == MODE_SOUNDER && o_ack[4] && !trig[4] |=> !o_on_q[4])
    else $error("sounder output not silenced by acknowledge");
  reset_ignored_a: assert property (@(posedge clk) disable iff (!rst_b)
    running && red_q[0] && alarm[0] && !alarm_rise[0] |=> red_q[0])
    else $error("red cleared while zone still in alarm");
  ack_steady_a: assert property (@(posedge clk) disable iff (!rst_b)
    zack[0] |=> ack_q[0] ##1 (r_q[0] || lamp_act_q || !red_q[0]))
    else $error("acknowledged zone red not steady");
endmodule // zaol_core

// ### rtl/zaol_pkg.sv
/*
  package for the zone alarm output logic: widths, modes, defaults, timing counts.
  assumes a 50 MHz system clock.
*/
package zaol_pkg;
  localparam int ZONES = 8;
  localparam int CLK_HZ = 50000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam int PULSE_S = 3;
  localparam int TIME_W = 8;
  localparam logic [TIME_W-1:0] PULSE_SECS = 8'h03;
  localparam logic [TIME_W-1:0] TIMED_DEF_SECS = 8'h3C;
  localparam int FLASH_HZ = 2;
  localparam int FLASH_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int LAMP_STEP_S = 1;
  localparam int DIAG_STEPS = 3;
  localparam int MODE_W = 3;
  localparam logic [MODE_W-1:0] MODE_NONLATCH = 3'h0;
  localparam logic [MODE_W-1:0] MODE_LATCHED = 3'h1;
  localparam logic [MODE_W-1:0] MODE_PULSED = 3'h2;
  localparam logic [MODE_W-1:0] MODE_TIMED = 3'h3;
  localparam logic [MODE_W-1:0] MODE_SOUNDER = 3'h4;
  localparam logic [MODE_W-1:0] MODE_DEF = MODE_LATCHED;
  localparam logic [63:0] MAP_DEF = 64'h8040201008040201;
  // digital control input functions
  localparam int DIN_ACK = 0;
  localparam int DIN_RESET = 1;
  localparam int DIN_LAMP = 2;
  localparam int DIN_SHUNT = 3;
endpackage

// ### rtl/zaol_tick.sv
/*
  tick generator: one-cycle pulse every CYC clocks, one second with the default CYC.
  assumes a free-running system clock.
*/
`timescale 1ns/10ps
module zaol_tick
  import zaol_pkg::*;
#(
  parameter int CYC = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  output logic tick
);
  logic [31:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    cnt_d = cnt_q + 32'h1;
    if (cnt_q >= 32'(CYC - 1)) begin
      cnt_d = 32'h0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule // zaol_tick

// ### rtl/zaol_sync.sv
/*
  two flip-flop synchroniser for a bus of pin levels.
  assumes asynchronous inputs.
*/
`timescale 1ns/10ps
module zaol_sync
  import zaol_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= INIT;
      s2_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  assign dout = s2_q;
endmodule // zaol_sync

// ### testbench/zaol_load.sv
/*
  siren, strobe and auxiliary device model: counts switch-on events per output.
  assumes registered active-high output levels on one clock.
*/
`timescale 1ns/10ps
module zaol_load
  import zaol_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ZONES-1:0] out_on,
  output logic [8*ZONES-1:0] act_q
);
  // ----------------------------------------
  // activation counter
  // ----------------------------------------
  logic [ZONES-1:0] last_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_q <= '0;
      act_q <= '0;
    end else begin
      last_q <= out_on;
      for (int o = 0; o < ZONES; o++) begin
        if (out_on[o] && !last_q[o]) begin
          act_q[o*8+:8] <= act_q[o*8+:8] + 8'h01;
        end
      end
    end
  end
endmodule // zaol_load

// ### testbench/tb.sv
/*
  bench for zaol_core: output modes, mapping, leds, power-up, control inputs.
  assumes a shortened tick and flash count and the device model beside it.
*/
`timescale 1ns/10ps
module tb
  import zaol_pkg::*;
;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] loop_short = 8'h00;
  logic [7:0] loop_open = 8'h00;
  logic [7:0] zone_btn_b = 8'hFF;
  logic [3:0] din_b = 4'hF;
  logic cfg_valid = 1'b0;
  logic [23:0] cfg_mode = 24'h000000;
  logic [63:0] cfg_time = 64'h0;
  logic [63:0] cfg_map = MAP_DEF;
  logic [7:0] out_on;
  logic [7:0] led_green;
  logic [7:0] led_red;
  logic [7:0] led_yellow;
  logic sounder;
  logic run;
  logic [63:0] act_q;
  logic sy = 1'b0;
  logic sr = 1'b0;
  logic [7:0] a;
  logic [7:0] e;
  int bad_count = 0;
  int compares = 0;
  int n;

  always #10 clk = ~clk;
  // remembers whether every yellow or every red lamp has been lit
  always @(negedge clk) begin
    if (led_yellow === 8'hFF) sy = 1'b1;
    if (led_red === 8'hFF) sr = 1'b1;
  end

  zaol_core #(.TICK(TK), .FLASH(4)) i_zaol_core (
    .clk(clk), .rst_b(rst_b), .loop_short(loop_short), .loop_open(loop_open),
    .zone_btn_b(zone_btn_b), .din_b(din_b), .cfg_valid(cfg_valid), .cfg_mode(cfg_mode),
    .cfg_time(cfg_time), .cfg_map(cfg_map), .out_on(out_on), .led_green(led_green),
    .led_red(led_red), .led_yellow(led_yellow), .sounder(sounder), .run(run)
  );
  zaol_load i_zaol_load (.clk(clk), .rst_b(rst_b), .out_on(out_on), .act_q(act_q));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [7:0] trig(input logic [63:0] m, input logic [7:0] al);
    trig = 8'h00;
    for (int o = 0; o < 8; o++) trig[o] = |(m[o*8+:8] & al);
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic zone(input int z, input logic v, input logic op);
    @(posedge clk);
    if (op) loop_open[z] <= v;
    else loop_short[z] <= v;
    cyc(6);
  endtask

  task automatic press(input logic dn, input int k);
    @(posedge clk);
    if (dn) din_b[k] <= 1'b0;
    else zone_btn_b[k] <= 1'b0;
    repeat (3) @(posedge clk);
    if (dn) din_b[k] <= 1'b1;
    else zone_btn_b[k] <= 1'b1;
    cyc(5);
  endtask

  task automatic red(input int z, input logic fl);
    n = 0;
    repeat (16) begin
      cyc(1);
      n += led_red[z];
    end
    if (fl) check("red_flash", n > 0 && n < 16, 1'b1);
    else check("red_steady", n, 16);
  endtask

  task automatic span(input int z, output int len);
    len = 0;
    while (out_on[z] !== 1'b1 && len < 20) begin
      cyc(1);
      len++;
    end
    len = 0;
    while (out_on[z] === 1'b1 && len < 400) begin
      cyc(1);
      len++;
    end
  endtask

  task automatic boot();
    @(posedge clk);
    rst_b <= 1'b0;
    cfg_valid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rst_out", {out_on, led_green, led_red, sounder, run}, 0);
    @(posedge clk);
    rst_b <= 1'b1;
    sy = 1'b0;
    sr = 1'b0;
    cyc(12);
    check("early_run", run, 1'b0);
    @(posedge clk);
    cfg_valid <= 1'b1;
    n = 0;
    while (run !== 1'b1 && n < 8 * TK) begin
      cyc(1);
      n++;
    end
    cyc(2);
    check("diag", {sy, sr, run}, 3'b111);
    check("idle_leds", {led_yellow, led_green, led_red}, 24'h00FF00);
  endtask

  task automatic mtest(input int z, input int s);
    int len;
    @(posedge clk);
    loop_short[z] <= 1'b1;
    span(z, len);
    check("span", len >= (s - 1) * TK - 2 && len <= s * TK + 6, 1'b1);
    zone(z, 1'b0, 1'b0);
    zone(z, 1'b1, 1'b0);
    check("rearm", out_on[z], 1'b1);
    cyc(TK);
    zone(z, 1'b0, 1'b0);
    @(posedge clk);
    loop_short[z] <= 1'b1;
    span(z, len);
    check("restart", len >= (s - 1) * TK - 2 && len <= s * TK + 6, 1'b1);
    zone(z, 1'b0, 1'b0);
    zone(z, 1'b1, 1'b0);
    press(1'b0, z);
    zone(z, 1'b0, 1'b0);
    check("held", out_on[z], 1'b1);
    press(1'b0, z);
    check("cut", {out_on[z], led_red[z]}, 2'b00);
    check("acts", act_q[z*8+:8], 8'h03);
    $display("test timer zone %0d done", z);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #400000;
    bad_count++;
    $display("BAD watchdog expected finish seen timeout");
    finish_test();
  end

  initial begin
    void'($urandom(32'h116E2906));
    // outputs 0..4 take the modes in code order, the rest at random
    for (int o = 0; o < 8; o++) begin
      cfg_mode[o*3+:3] <= (o < 5) ? 3'(o) : 3'($urandom_range(4, 0));
      cfg_time[o*8+:8] <= 8'($urandom_range(6, 3));
    end
    boot();
    zone(0, 1'b1, 1'b0);
    check("on0", out_on, 8'h01);
    check("alarm0", {led_green[0], sounder}, 2'b01);
    red(0, 1'b1);
    zone(0, 1'b0, 1'b0);
    check("off0", out_on[0], 1'b0);
    zone(0, 1'b1, 1'b0);
    press(1'b0, 0);
    check("ack0", {sounder, led_red[0], out_on[0]}, 3'b011);
    red(0, 1'b0);
    zone(0, 1'b0, 1'b0);
    check("secure0", {led_green[0], out_on[0]}, 2'b10);
    press(1'b0, 0);
    check("clear0", led_red[0], 1'b0);
    $display("test nonlatch done");
    zone(1, 1'b1, 1'b1);
    check("on1", {out_on, led_green[1], sounder}, 10'h009);
    red(1, 1'b1);
    press(1'b1, DIN_ACK);
    check("ack1", {sounder, out_on[1]}, 2'b01);
    press(1'b1, DIN_RESET);
    check("early_rst", {out_on[1], led_red[1]}, 2'b11);
    zone(1, 1'b0, 1'b1);
    check("hold1", out_on[1], 1'b1);
    press(1'b1, DIN_RESET);
    check("rst1", {out_on[1], led_red[1]}, 2'b00);
    $display("test latched done");
    mtest(2, PULSE_S);
    mtest(3, int'(cfg_time[31:24]));
    zone(4, 1'b1, 1'b0);
    check("on4", out_on, 8'h10);
    press(1'b0, 4);
    check("ack4", {out_on[4], sounder}, 2'b00);
    zone(4, 1'b0, 1'b0);
    zone(4, 1'b1, 1'b0);
    check("again4", out_on[4], 1'b1);
    press(1'b0, 4);
    zone(4, 1'b0, 1'b0);
    press(1'b0, 4);
    $display("test sounder done");
    sy = 1'b0;
    sr = 1'b0;
    press(1'b1, DIN_LAMP);
    cyc(4 * TK);
    check("lamp", {sy, sr}, 2'b11);
    press(1'b1, DIN_SHUNT);
    check("back", {led_yellow, led_green, led_red}, 24'h00FF00);
    $display("test controls done");
    @(posedge clk);
    cfg_mode <= {{2{MODE_LATCHED}}, MODE_NONLATCH, {5{MODE_LATCHED}}};
    cfg_map <= {$urandom, $urandom} | 64'h2020200000000000;
    boot();
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 8'h20 : 8'($urandom_range(255, 1));
      e = trig(cfg_map, a);
      @(posedge clk);
      n = $urandom;
      loop_short <= a & n[7:0];
      loop_open <= a & ~n[7:0];
      cyc(6);
      check("map_on", {out_on, sounder}, {e, 1'b1});
      @(posedge clk);
      loop_short <= 8'h00;
      loop_open <= 8'h00;
      cyc(6);
      check("map_off", out_on, e & 8'hDF);
      press(1'b1, DIN_ACK);
      press(1'b1, DIN_RESET);
      check("cleared", {out_on, led_red, sounder}, 0);
    end
    $display("test mapping done");
    finish_test();
  end
endmodule // tb
